/* File: design/pcirq_pkg.sv */
// Package for the pin-change interrupt aggregator: register map, bit positions, types.
// Assumes a 32-bit APB register bus; every register is one aligned word.
package pcirq_pkg;
  // Port widths of the extended ports
  localparam int PCIRQ_A_W = 6;
  localparam int PCIRQ_E_W = 6;
  localparam int PCIRQ_G_W = 8;
  localparam int PCIRQ_SUB_W = 8;
  localparam int PCIRQ_PL_W = 4;
  localparam int PCIRQ_NSUB = 4;
  localparam int PCIRQ_USER_W = 8;
  // Port-level bit positions
  localparam int PCIRQ_BIT_A = 0;
  localparam int PCIRQ_BIT_E = 1;
  localparam int PCIRQ_BIT_G = 2;
  localparam int PCIRQ_BIT_J = 3;
  localparam int PCIRQ_BIT_K = 4;
  localparam int PCIRQ_BIT_PL = 5;
  localparam logic [7:0] PCIRQ_PORT_BITS = 8'h3F;
  // Byte addresses
  localparam logic [7:0] PCIRQ_ADDR_FLAGS = 8'h00;
  localparam logic [7:0] PCIRQ_ADDR_CTRL = 8'h04;
  localparam logic [7:0] PCIRQ_ADDR_MASK = 8'h08;
  localparam logic [7:0] PCIRQ_ADDR_UFLAGS = 8'h0C;
  localparam logic [7:0] PCIRQ_ADDR_UCTRL = 8'h10;
  localparam logic [7:0] PCIRQ_ADDR_UMASK = 8'h14;
  localparam logic [7:0] PCIRQ_ADDR_EN_A = 8'h20;
  localparam logic [7:0] PCIRQ_ADDR_EN_E = 8'h24;
  localparam logic [7:0] PCIRQ_ADDR_EN_G = 8'h28;
  localparam logic [7:0] PCIRQ_ADDR_EN_J0 = 8'h2C;
  localparam logic [7:0] PCIRQ_ADDR_EN_K0 = 8'h3C;
  localparam logic [7:0] PCIRQ_ADDR_EN_PL = 8'h4C;
  localparam logic [7:0] PCIRQ_RESET_VAL = 8'h00;
  localparam logic [31:0] PCIRQ_ZERO32 = 32'h0000_0000;

  typedef struct packed {
    logic [PCIRQ_A_W-1:0] a;
    logic [PCIRQ_E_W-1:0] e;
    logic [PCIRQ_G_W-1:0] g;
    logic [PCIRQ_NSUB*PCIRQ_SUB_W-1:0] j;
    logic [PCIRQ_NSUB*PCIRQ_SUB_W-1:0] k;
    logic [PCIRQ_PL_W-1:0] pl;
  } pcirq_pins_t;

  typedef struct packed {
    logic port_irq;
    logic user_irq;
  } pcirq_irq_t;
endpackage : pcirq_pkg

/* File: design/pcirq_top.sv */
// Pin-change interrupt aggregator: per-pin enables, port-level and user-block
// flag/control/mask registers, APB slave. Pins are synchronous to clock.

// Overview of operation
// - Every pin of each extended port is watched for level changes.
// - Per-pin enable register per port and per J/K sub-port; cleared bit blocks that pin's notification.
// - Port-level bit 0 port A, 1 port E, 2 port G, 5 PLL port.
// - Bit 3 ORs all J sub-ports; bit 4 ORs all K sub-ports.
// - Port flag sets on notification only while its mask bit is set.
// - Port and user flags clear on write-one; write-zero leaves them.
// - Port interrupt raised while any flag bit and its control bit set.
// - User-block requests gathered in a separate collector module.
// - User-block bit meanings are defined by whoever builds the blocks.
// - User flag sets on notification only while its mask bit is set.
// - User interrupt raised while any user flag and control bit set.
// - All interrupt mask, control, enable and flag registers reset to zero.
module pcirq_user_collector import pcirq_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_sync_n,
  // Sources
  input wire logic [PCIRQ_USER_W-1:0] user_req,
  // Register writes
  input wire logic wr_flags,
  input wire logic wr_ctrl,
  input wire logic wr_mask,
  input wire logic [PCIRQ_USER_W-1:0] wdata,
  // State
  output logic [PCIRQ_USER_W-1:0] flags_ff,
  output logic [PCIRQ_USER_W-1:0] ctrl_ff,
  output logic [PCIRQ_USER_W-1:0] mask_ff,
  output logic irq_ff
);
  // Meaning of each bit belongs to the user-block build
  logic [PCIRQ_USER_W-1:0] nxt_flags;
  logic [PCIRQ_USER_W-1:0] clr;

  always_comb begin
    clr = wr_flags ? wdata : '0;
    nxt_flags = (flags_ff & ~clr) | (user_req & mask_ff);
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flags_ff <= '0;
      ctrl_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      if (wr_ctrl) ctrl_ff <= wdata;
      if (wr_mask) mask_ff <= wdata;
      irq_ff <= |(nxt_flags & ctrl_ff);
    end
  end
endmodule : pcirq_user_collector

module pcirq_top import pcirq_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Extended port pins
  input wire pcirq_pins_t pins,
  // User-block requests
  input wire logic [PCIRQ_USER_W-1:0] user_req,
  // Interrupts
  output pcirq_irq_t irq
);
  localparam int NEN = 3 + 2*PCIRQ_NSUB + 1;
  localparam int NPINS = $bits(pcirq_pins_t);

  logic rst_meta_ff;
  logic rst_sync_n;
  logic [NPINS-1:0] pin_prev_ff;
  logic [7:0] en_ff [NEN];
  logic [7:0] flags_ff, ctrl_ff, mask_ff;
  logic port_irq_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic [PCIRQ_USER_W-1:0] uflags, uctrl, umask;
  logic user_irq;
  logic [7:0] notify;
  logic [7:0] nxt_flags;
  logic wr_acc, rd_setup;
  logic [31:0] nxt_rdata;
  logic nxt_err;

  // Per-port pin change vector, pins zero-extended to eight bits
  function automatic logic [7:0] chg8(input logic [7:0] cur, input logic [7:0] prv,
                                      input logic [7:0] en);
    return (cur ^ prv) & en;
  endfunction

  // Index of an enable register, or NEN when not one
  function automatic int en_index(input logic [7:0] addr);
    int idx;
    idx = NEN;
    if (addr >= PCIRQ_ADDR_EN_A && addr <= PCIRQ_ADDR_EN_PL && addr[1:0] == 2'b00)
      idx = int'((addr - PCIRQ_ADDR_EN_A) >> 2);
    return idx;
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n <= rst_meta_ff;
    end
  end

  // Previous sample; first cycle after reset sees no change
  logic primed_ff;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_prev_ff <= '0;
      primed_ff <= 1'b0;
    end else begin
      pin_prev_ff <= pins;
      primed_ff <= 1'b1;
    end
  end

  // Pin changes qualified by enables, folded into port-level bits
  pcirq_pins_t prv;
  always_comb begin
    logic [7:0] c;
    c = '0;
    prv = pcirq_pins_t'(pin_prev_ff);
    notify = '0;
    c = chg8(8'(pins.a), 8'(prv.a), en_ff[0]);
    notify[PCIRQ_BIT_A] = |c;
    c = chg8(8'(pins.e), 8'(prv.e), en_ff[1]);
    notify[PCIRQ_BIT_E] = |c;
    c = chg8(pins.g, prv.g, en_ff[2]);
    notify[PCIRQ_BIT_G] = |c;
    for (int s = 0; s < PCIRQ_NSUB; s++) begin
      c = chg8(pins.j[s*8 +: 8], prv.j[s*8 +: 8], en_ff[3+s]);
      notify[PCIRQ_BIT_J] = notify[PCIRQ_BIT_J] | (|c);
      c = chg8(pins.k[s*8 +: 8], prv.k[s*8 +: 8], en_ff[3+PCIRQ_NSUB+s]);
      notify[PCIRQ_BIT_K] = notify[PCIRQ_BIT_K] | (|c);
    end
    c = chg8(8'(pins.pl), 8'(prv.pl), en_ff[NEN-1]);
    notify[PCIRQ_BIT_PL] = |c;
    if (!primed_ff) notify = '0;
  end

  // APB decode: zero-wait access, writes take effect in the access cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // Set wins over a simultaneous write-one clear
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_acc && paddr == PCIRQ_ADDR_FLAGS) nxt_flags = flags_ff & ~pwdata[7:0];
    nxt_flags = (nxt_flags | (notify & mask_ff)) & PCIRQ_PORT_BITS;
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flags_ff <= PCIRQ_RESET_VAL;
      port_irq_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      port_irq_ff <= |(nxt_flags & ctrl_ff);
    end
  end

  // Full-byte writes only; software does read-modify-write for single bits
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_ff <= PCIRQ_RESET_VAL;
      mask_ff <= PCIRQ_RESET_VAL;
      for (int i = 0; i < NEN; i++) en_ff[i] <= PCIRQ_RESET_VAL;
    end else if (wr_acc) begin
      if (paddr == PCIRQ_ADDR_CTRL) ctrl_ff <= pwdata[7:0] & PCIRQ_PORT_BITS;
      if (paddr == PCIRQ_ADDR_MASK) mask_ff <= pwdata[7:0] & PCIRQ_PORT_BITS;
      for (int i = 0; i < NEN; i++)
        if (en_index(paddr) == i) en_ff[i] <= pwdata[7:0];
    end
  end

  pcirq_user_collector u_collect (
    .clock(clock),
    .rst_sync_n(rst_sync_n),
    .user_req(user_req),
    .wr_flags(wr_acc && paddr == PCIRQ_ADDR_UFLAGS),
    .wr_ctrl(wr_acc && paddr == PCIRQ_ADDR_UCTRL),
    .wr_mask(wr_acc && paddr == PCIRQ_ADDR_UMASK),
    .wdata(pwdata[PCIRQ_USER_W-1:0]),
    .flags_ff(uflags),
    .ctrl_ff(uctrl),
    .mask_ff(umask),
    .irq_ff(user_irq)
  );

  // Read mux; unmapped addresses answer with an error
  always_comb begin
    int ei;
    ei = en_index(paddr);
    nxt_rdata = PCIRQ_ZERO32;
    nxt_err = 1'b0;
    case (paddr)
      PCIRQ_ADDR_FLAGS: nxt_rdata[7:0] = flags_ff;
      PCIRQ_ADDR_CTRL: nxt_rdata[7:0] = ctrl_ff;
      PCIRQ_ADDR_MASK: nxt_rdata[7:0] = mask_ff;
      PCIRQ_ADDR_UFLAGS: nxt_rdata[7:0] = uflags;
      PCIRQ_ADDR_UCTRL: nxt_rdata[7:0] = uctrl;
      PCIRQ_ADDR_UMASK: nxt_rdata[7:0] = umask;
      default: begin
        if (ei < NEN) nxt_rdata[7:0] = en_ff[ei];
        else nxt_err = 1'b1;
      end
    endcase
  end

  // Answer registered in setup so every output is a flip-flop
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata_ff <= PCIRQ_ZERO32;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= rd_setup;
      if (rd_setup) begin
        prdata_ff <= pwrite ? PCIRQ_ZERO32 : nxt_rdata;
        pslverr_ff <= nxt_err;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq.port_irq = port_irq_ff;
  assign irq.user_irq = user_irq;
endmodule : pcirq_top

/* File: tb/pcirq_top_sva.sv */
// Checker for the aggregator's port behaviour.
// Assumes the design package and the top module's ports.
module pcirq_top_chk import pcirq_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sources and requests
  input wire pcirq_pins_t pins,
  input wire logic [PCIRQ_USER_W-1:0] user_req,
  input wire pcirq_irq_t irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  pcirq_pins_t pins_q;
  logic [3:0] chg_q;
  logic [3:0] ur_q;
  logic [3:0] wr_q;
  // Short cause history: request moves need a recent cause
  always_ff @(posedge clock) begin
    pins_q <= pins;
    chg_q <= {chg_q[2:0], pins != pins_q};
    ur_q <= {ur_q[2:0], |user_req};
    wr_q <= {wr_q[2:0], psel && penable && pwrite};
  end
  chk_setup_answer: assert property (psel && !penable |=> pready)
    else $error("setup not answered");
  chk_ready_once: assert property (pready |=> !pready) else $error("pready held");
  chk_err_pair: assert property (pslverr |-> pready) else $error("lone pslverr");
  chk_port_width: assert property (pready && !pwrite && paddr < 8'h0C |->
    prdata[31:6] == 26'h0) else $error("unused port bits read set");
  chk_port_rise: assert property ($rose(irq.port_irq) |-> |chg_q || |wr_q)
    else $error("port request rose without cause");
  chk_port_fall: assert property ($fell(irq.port_irq) |-> |wr_q)
    else $error("port request fell without write");
  chk_user_rise: assert property ($rose(irq.user_irq) |-> |ur_q || |wr_q)
    else $error("user request rose without cause");
  chk_user_fall: assert property ($fell(irq.user_irq) |-> |wr_q)
    else $error("user request fell without write");
  chk_reset_quiet: assert property ($rose(rst_n) |-> irq == '0 && !pready)
    else $error("active after reset");
endmodule // pcirq_top_chk

bind pcirq_top pcirq_top_chk chk_u (.clock(clock), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pins(pins), .user_req(user_req), .irq(irq));

/* File: tb/pcirq_core_model.sv */
// Core-side bus master: APB transfers to the register block.
// Assumes a slave that answers with pready; the wait is bounded.
module pcirq_core_model (
  // Clock
  input wire logic clock,
  // Bus
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic se, output logic to);
    to = 1'b1;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    for (int n = 0; n < 16 && to; n++) begin
      @(posedge clock);
      if (pready) begin
        rd = prdata;
        se = pslverr;
        to = 1'b0;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep looking valid
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule // pcirq_core_model

/* File: tb/pcirq_top_test.sv */
// Bench for the aggregator: register access, pin changes, user requests.
// Assumes the core model and the design package.
module pcirq_top_test import pcirq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  pcirq_pins_t pins;
  logic [PCIRQ_USER_W-1:0] user_req;
  pcirq_irq_t irq;
  int num_errors, n_compared;
  localparam logic [7:0] EN_ADDR [6] = '{8'h20, 8'h24, 8'h28, 8'h38, 8'h44, 8'h4C};
  localparam logic [7:0] EN_VAL [6] = '{8'h20, 8'h01, 8'h80, 8'h80, 8'h01, 8'h08};
  localparam int PIN_IDX [6] = '{87, 76, 75, 67, 20, 3};
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  pcirq_core_model m_u (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pcirq_top dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .user_req(user_req), .irq(irq));
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic ee);
    logic [31:0] rd;
    logic se;
    logic to;
    m_u.xfer(we, a, d, rd, se, to);
    if (to) begin
      num_errors++;
      wrap_up();
    end
    if (!we) cmp("rdata", e, rd);
    cmp("pslverr", {31'h0, ee}, {31'h0, se});
  endtask
  task automatic tog(input int i);
    @(posedge clock);
    pins <= pins ^ (pcirq_pins_t'(1) << i);
    repeat (4) @(posedge clock);
  endtask
  task automatic upulse();
    @(posedge clock);
    user_req <= 8'hFF;
    @(posedge clock);
    user_req <= 8'h00;
  endtask
  initial begin
    rst_n = 1'b0;
    pins = '0;
    user_req = '0;
    num_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int a = 0; a <= 8'h50; a += 4) acc(0, 8'(a), 0, 0, a inside {24, 28, 80});
    acc(1, 8'h18, 32'hFF, 0, 1);
    acc(1, 8'h04, 32'hFF, 0, 0);
    acc(0, 8'h04, 0, 32'h3F, 0);
    acc(1, 8'h04, 0, 0, 0);
    acc(1, 8'h08, 32'h3F, 0, 0);
    for (int i = 0; i < 6; i++) begin
      tog(PIN_IDX[i]);
      acc(0, 8'h00, 0, 0, 0);
      acc(0, EN_ADDR[i], 0, 0, 0);
      acc(1, EN_ADDR[i], EN_VAL[i], 0, 0);
      acc(1, 8'h08, 32'h3F ^ (1 << i), 0, 0);
      tog(PIN_IDX[i]);
      acc(0, 8'h00, 0, 0, 0);
      acc(1, 8'h08, 32'h3F, 0, 0);
      tog(PIN_IDX[i]);
      acc(0, 8'h00, 0, 1 << i, 0);
      cmp("port_irq", 0, irq.port_irq);
      acc(1, 8'h04, 1 << i, 0, 0);
      acc(1, 8'h00, 0, 0, 0);
      cmp("port_irq", 1, irq.port_irq);
      acc(1, 8'h00, 1 << i, 0, 0);
      acc(0, 8'h00, 0, 0, 0);
      cmp("port_irq", 0, irq.port_irq);
      acc(1, 8'h04, 0, 0, 0);
    end
    upulse();
    acc(0, 8'h0C, 0, 0, 0);
    acc(1, 8'h14, 32'hA5, 0, 0);
    upulse();
    acc(0, 8'h0C, 0, 32'hA5, 0);
    acc(1, 8'h10, 32'h01, 0, 0);
    acc(0, 8'h10, 0, 32'h01, 0);
    cmp("user_irq", 1, irq.user_irq);
    acc(1, 8'h0C, 32'h01, 0, 0);
    acc(0, 8'h0C, 0, 32'hA4, 0);
    cmp("user_irq", 0, irq.user_irq);
    wrap_up();
  end
endmodule // pcirq_top_test
